// file: dscg_defines.vh
`ifndef DSCG_DEFINES_VH
`define DSCG_DEFINES_VH

// ==========================================================================
// Register offsets (byte addresses).
`define DSCG_OFF_RUN_GATE       12'h104
`define DSCG_OFF_SLEEP_GATE     12'h114
`define DSCG_OFF_DEEP_GATE      12'h124
`define DSCG_OFF_RUN_CLK_CFG    12'h060
`define DSCG_OFF_IRQ_STATUS     12'h200
`define DSCG_OFF_IRQ_MASK       12'h204

// ==========================================================================
// Gating field positions.
`define DSCG_BIT_COMP_B         25
`define DSCG_BIT_COMP_A         24
`define DSCG_BIT_CNT_B          17
`define DSCG_BIT_CNT_A          16
`define DSCG_BIT_SYNC_SER       4
`define DSCG_BIT_ASYNC_SER      0
`define DSCG_GATE_WMASK         32'h0303_0011
`define DSCG_GATE_RESET         32'h0000_0000

// ==========================================================================
// Run clock configuration and interrupt fields.
`define DSCG_BIT_AUTO_GATE      27
`define DSCG_CFG_WMASK          32'h0800_0000
`define DSCG_CFG_RESET          32'h0000_0000
`define DSCG_IRQ_FAULT          0
`define DSCG_IRQ_MODE           1
`define DSCG_IRQ_WMASK          32'h0000_0003
`define DSCG_IRQ_RESET          32'h0000_0000

// ==========================================================================
// Power modes and peripheral count.
`define DSCG_MODE_RUN           2'h0
`define DSCG_MODE_SLEEP         2'h1
`define DSCG_MODE_DEEP          2'h2
`define DSCG_NUM_PERIPH         6

`endif

// file: dscg_sync2.v
`timescale 1ns/1ns
// ==========================================================================
// Two-stage synchroniser for one level.
module dscg_sync2
(
	// Clock and reset.
	input  wire pclk,
	input  wire presetn,
	// Level in and out.
	input  wire din,
	output reg  dout
);
	reg meta_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end
		else
		begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // dscg_sync2

// file: dscg_gate.v
`timescale 1ns/1ns
`include "dscg_defines.vh"
// Function
// [R1] Each writable gating bit is the clock enable of one peripheral.
// [R2] A bus access to a peripheral whose enable is clear gets a bus fault.
// [R3] All gating bits read zero after reset, so every peripheral is off.
// [R4] Software must set the enable of each peripheral before using it.
// [R5] Run, sleep and deep-sleep gating registers exist with one layout.
// [R6] Sleep gating applies only while the automatic selection bit is set.
// [R7] Bits 25 and 24 gate comparator b and comparator a.
// [R8] Bits 17 and 16 gate counter b and counter a.
// [R9] Bit 4 gates the synchronous serial port.
// [R10] Bit 0 gates the asynchronous serial port.
// [R11] Bits 31:26, 23:18, 15:5 and 3:1 are read-only zero.
// [R12] Software keeps reserved bits by read-modify-write.
// [R13] Deep-sleep gating applies only in deep sleep; run gating applies in run mode.
module dscg_gate
(
	// APB slave.
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Power mode requests from the core, asynchronous levels.
	input  wire        sleep_req,
	input  wire        deep_req,
	// Peripheral bus accesses, one request bit per peripheral.
	input  wire [5:0]  periph_access,
	output reg  [5:0]  periph_fault,
	// Peripheral clock enables and interrupt.
	output reg  [5:0]  periph_clk_en,
	output reg         irq
);
	// ======================================================================
	// Registers.
	reg [31:0] run_gate_reg_one_q;
	reg [31:0] sleep_gate_reg_one_q;
	reg [31:0] deep_sleep_gate_reg_one_q;
	reg [31:0] run_clock_config_reg_q;
	reg [31:0] irq_status_q;
	reg [31:0] irq_mask_q;
	reg [1:0]  mode_q;
	reg [1:0]  mode_d;
	reg [31:0] rdata_d;
	reg        hit_d;
	reg [31:0] sel_gate;
	reg [31:0] irq_status_d;
	wire       sleep_s;
	wire       deep_s;
	wire       auto_gate_select;
	wire       access_ph;
	wire       wr_en;
	wire       rd_en;
	wire [5:0] gate_vec;

	// ======================================================================
	// Mode inputs cross in through two flops each.
	dscg_sync2 u_sync_sleep
	(
		.pclk    (pclk),
		.presetn (presetn),
		.din     (sleep_req),
		.dout    (sleep_s)
	);
	dscg_sync2 u_sync_deep
	(
		.pclk    (pclk),
		.presetn (presetn),
		.din     (deep_req),
		.dout    (deep_s)
	);

	assign auto_gate_select = run_clock_config_reg_q[`DSCG_BIT_AUTO_GATE];

	// Deep sleep has priority over sleep when both are requested.
	always @*
	begin
		if (deep_s)
			mode_d = `DSCG_MODE_DEEP;
		else if (sleep_s)
			mode_d = `DSCG_MODE_SLEEP;
		else
			mode_d = `DSCG_MODE_RUN;
	end

	// ======================================================================
	// Gating selection.
	always @*
	begin
		// Without automatic selection the run set holds in every mode. see [R6]
		case (mode_q)
			`DSCG_MODE_SLEEP:
				sel_gate = auto_gate_select ? sleep_gate_reg_one_q
				                            : run_gate_reg_one_q;
			`DSCG_MODE_DEEP:
				sel_gate = auto_gate_select ? deep_sleep_gate_reg_one_q
				                            : run_gate_reg_one_q; // see [R13]
			default:
				sel_gate = run_gate_reg_one_q; // see [R13]
		endcase
	end

	// Bit order of the enable vector: ser_a, ser_s, cnt_a, cnt_b, cmp_a, cmp_b.
	assign gate_vec = {sel_gate[`DSCG_BIT_COMP_B],   // see [R7]
	                   sel_gate[`DSCG_BIT_COMP_A],   // see [R7]
	                   sel_gate[`DSCG_BIT_CNT_B],    // see [R8]
	                   sel_gate[`DSCG_BIT_CNT_A],    // see [R8]
	                   sel_gate[`DSCG_BIT_SYNC_SER], // see [R9]
	                   sel_gate[`DSCG_BIT_ASYNC_SER]}; // see [R10]

	// ======================================================================
	// APB decode; every access completes in its second access cycle, after one wait state.
	assign access_ph = psel & penable & ~pready;
	assign wr_en     = access_ph & pwrite;
	assign rd_en     = access_ph & ~pwrite;

	always @*
	begin
		hit_d   = 1'b1;
		rdata_d = 32'h0000_0000;
		case (paddr)
			`DSCG_OFF_RUN_GATE:    rdata_d = run_gate_reg_one_q;
			`DSCG_OFF_SLEEP_GATE:  rdata_d = sleep_gate_reg_one_q;
			`DSCG_OFF_DEEP_GATE:   rdata_d = deep_sleep_gate_reg_one_q;
			`DSCG_OFF_RUN_CLK_CFG: rdata_d = run_clock_config_reg_q;
			`DSCG_OFF_IRQ_STATUS:  rdata_d = irq_status_q;
			`DSCG_OFF_IRQ_MASK:    rdata_d = irq_mask_q;
			default:               hit_d   = 1'b0;
		endcase
	end

	// Events set sticky bits; a set in the clearing cycle wins.
	always @*
	begin
		irq_status_d = irq_status_q;
		if (rd_en && paddr == `DSCG_OFF_IRQ_STATUS)
			irq_status_d = 32'h0000_0000;
		if (|(periph_access & ~gate_vec))
			irq_status_d[`DSCG_IRQ_FAULT] = 1'b1;
		if (mode_d != mode_q)
			irq_status_d[`DSCG_IRQ_MODE] = 1'b1;
	end

	// ======================================================================
	// Register state.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// All peripherals start unclocked. see [R3]
			run_gate_reg_one_q        <= `DSCG_GATE_RESET;
			sleep_gate_reg_one_q      <= `DSCG_GATE_RESET;
			deep_sleep_gate_reg_one_q <= `DSCG_GATE_RESET;
			run_clock_config_reg_q    <= `DSCG_CFG_RESET;
			irq_status_q              <= `DSCG_IRQ_RESET;
			irq_mask_q                <= `DSCG_IRQ_RESET;
			mode_q                    <= `DSCG_MODE_RUN;
			prdata                    <= 32'h0000_0000;
			pready                    <= 1'b0;
			pslverr                   <= 1'b0;
			periph_fault              <= 6'h00;
			periph_clk_en             <= 6'h00;
			irq                       <= 1'b0;
		end
		else
		begin
			mode_q       <= mode_d;
			irq_status_q <= irq_status_d & `DSCG_IRQ_WMASK;
			pready       <= access_ph;
			pslverr      <= access_ph & ~hit_d;
			prdata       <= rd_en ? rdata_d : 32'h0000_0000;
			if (wr_en)
			begin
				// Reserved bits are masked off on every write. see [R11]
				case (paddr)
					`DSCG_OFF_RUN_GATE:
						run_gate_reg_one_q <= pwdata & `DSCG_GATE_WMASK;
					`DSCG_OFF_SLEEP_GATE:
						sleep_gate_reg_one_q <= pwdata & `DSCG_GATE_WMASK;
					`DSCG_OFF_DEEP_GATE: // see [R5]
						deep_sleep_gate_reg_one_q <=
							pwdata & `DSCG_GATE_WMASK;
					`DSCG_OFF_RUN_CLK_CFG:
						run_clock_config_reg_q <= pwdata & `DSCG_CFG_WMASK;
					`DSCG_OFF_IRQ_MASK:
						irq_mask_q <= pwdata & `DSCG_IRQ_WMASK;
					default:
						irq_mask_q <= irq_mask_q;
				endcase
			end
			// Enable follows the selected set one cycle later. see [R1]
			periph_clk_en <= gate_vec;
			// Accesses to an unclocked unit are faulted. see [R2]
			periph_fault  <= periph_access & ~gate_vec;
			irq           <= |(irq_status_d & irq_mask_q);
		end
	end
endmodule // dscg_gate

// file: dscg_gate_properties.sv
`timescale 1ns/1ns
// ==========================================
// Port checks for the gating block.
module dscg_gate_properties
(
	// APB slave.
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Modes, accesses and enables.
	input wire        sleep_req,
	input wire        deep_req,
	input wire [5:0]  periph_access,
	input wire [5:0]  periph_fault,
	input wire [5:0]  periph_clk_en,
	input wire        irq
);
	wire map_ok = paddr == 12'h104 || paddr == 12'h114 || paddr == 12'h124
		|| paddr == 12'h060 || paddr == 12'h200 || paddr == 12'h204;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Mode requests pass a synchroniser, so quiet must outlast it.
	sequence s_quiet;
		(!pready && !sleep_req && !deep_req)[*8];
	endsequence
	a_ready_wait: assert property (
		psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_pulse: assert property (
		pready |=> !pready) else $error("pready held");
	a_rdata_idle: assert property (
		!pready |-> prdata == 32'h0) else $error("prdata not idle");
	a_reserved_zero: assert property (
		pready && !pwrite && paddr == 12'h124
		|-> (prdata & ~32'h0303_0011) == 32'h0) else $error("reserved set");
	a_slverr_map: assert property (
		pready |-> pslverr == !map_ok) else $error("pslverr wrong");
	a_fault_gate: assert property (
		$stable(periph_clk_en) |-> periph_fault ==
		($past(periph_access) & ~periph_clk_en)) else $error("fault wrong");
	a_reset_off: assert property (
		$rose(presetn) |-> periph_clk_en == 6'h0 && !irq)
		else $error("enables after reset");
	a_enable_quiet: assert property (
		s_quiet |-> $stable(periph_clk_en)) else $error("enable moved");
endmodule // dscg_gate_properties

bind dscg_gate dscg_gate_properties u_props (.*);

// file: dscg_gate_tb.sv
`timescale 1ns/1ns
module dscg_gate_tb;
	reg        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg        sleep_req = 0, deep_req = 0, er;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd, v, r;
	reg [5:0]  periph_access = 0, a;
	wire [31:0] prdata;
	wire        pready, pslverr, irq;
	wire [5:0]  periph_fault, periph_clk_en;
	integer     err_count = 0, cmp_count = 0, i, n;
	always #5 pclk = ~pclk;
	dscg_gate DUT (.*);
	task test_done;
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input [31:0] e, input [31:0] g);
		cmp_count++;
		if (e !== g)
		begin
			err_count++;
			$display("mismatch %0s expected %h seen %h", s, e, g);
		end
	endtask
	function [5:0] en(input [31:0] x);
		en = {x[25], x[24], x[17], x[16], x[4], x[0]};
	endfunction
	task apb(input w, input [11:0] ad, input [31:0] d);
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
		@(posedge pclk) penable <= 1;
		n = 0;
		@(posedge pclk);
		while (!pready)
		begin
			n++;
			if (n > 20) begin err_count++; test_done; end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task flt(input [5:0] ac, input [5:0] ex);
		@(posedge pclk) periph_access <= ac;
		@(posedge pclk) periph_access <= 0;
		@(posedge pclk) chk("fault", ex, periph_fault);
	endtask
	task mode(input s, input d);
		@(posedge pclk) {sleep_req, deep_req} <= {s, d};
		repeat (8) @(posedge pclk);
	endtask
	initial
	begin
		void'($urandom(32'h24C7));
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h124, 0);
		chk("deep", 0, rd);
		chk("clk_en", 0, periph_clk_en);
		apb(1, 12'h204, 1);
		flt(6'h3F, 6'h3F);
		repeat (3) @(posedge pclk);
		chk("irq", 1, irq);
		apb(0, 12'h200, 0);
		chk("status", 1, rd[0]);
		repeat (2) @(posedge pclk);
		chk("irq", 0, irq);
		apb(0, 12'hFFC, 0);
		chk("slverr", 1, er);
		chk("unmapped", 0, rd);
		apb(1, 12'h060, 32'h0800_0000);
		for (i = 0; i < 8; i++)
		begin
			v = $urandom;
			r = $urandom;
			a = $urandom;
			apb(1, 12'h124, v);
			apb(0, 12'h124, 0);
			chk("deep", v & 32'h0303_0011, rd);
			apb(1, 12'h104, r);
			apb(1, 12'h114, ~v);
			mode(i[0], !i[0]);
			chk("gate", en(i[0] ? ~v : v), periph_clk_en);
			flt(a, a & ~en(i[0] ? ~v : v));
			mode(0, 0);
			chk("run", en(r), periph_clk_en);
		end
		apb(1, 12'h060, 0);
		mode(0, 1);
		chk("no auto", en(r), periph_clk_en);
		// Software enables the async serial port by read-modify-write.
		apb(0, 12'h104, 0);
		apb(1, 12'h104, rd | 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk("enable", en(r | 32'h1), periph_clk_en);
		test_done;
	end
endmodule // dscg_gate_tb
